// ---- design/owi_slave.sv ----
// Functional notes
// [R1] Link shares the output pin, both directions.
// [R2] Normal output starts after power-up delay.
// [R3] Master holds pin high, then enters early.
// [R4] Master overdrives the active output buffer.
// [R5] Sensor is always slave, never master.
// [R6] Start is a rising edge after LOW.
// [R7] Command byte follows start; read or write.
// [R8] Data follows command byte without gap.
// [R9] Reads carry handover bits around data.
// [R10] Stop is rising edge, then held HIGH.
// [R11] No rising edge too long: back to idle.
// [R12] Entry uses the ordinary write framing.
// [R13] Command mode persists until power-on reset.
// [R14] Start LOW and stop HIGH minimum durations.
// [R15] Bit coded by HIGH width per period.
// [R16] Command mode grants memory and control access.
// [R17] Master rewrites checksum after memory changes.
// [R18] Link reset guaranteed after 250 us silence.
// [R19] Bit period 10 to 100 us.
// [R20] Command: seven address bits, low bit read.
// [R21] Bit is one when HIGH exceeds half.
// [R22] Drive only for takeover, data, handback.
`timescale 1ns/1ps
`include "owi_consts.svh"
module pgm_slave #(
   parameter int IDLE_TIMEOUT_CYC = `PGM_US2CYC(`PGM_IDLE_TIMEOUT_US),
   parameter int BIT_MAX_CYC = `PGM_US2CYC(`PGM_BIT_MAX_US),
   parameter int POWER_UP_CYC = 1000,
   parameter int ENTRY_WINDOW_CYC = 1000000,
   parameter logic [6:0] SIG_ADDR = 7'h00
)
(
   pgm_if.slave link,
   input wire logic clk,
   input wire logic rstn,
   input wire logic normal_level,
   input wire pgm_pkg::word_t rd_data,
   output logic normal_mode,
   output logic cmd_mode,
   output logic wr_strobe,
   output pgm_pkg::addr_t wr_addr,
   output pgm_pkg::word_t wr_data,
   output logic rd_strobe,
   output pgm_pkg::addr_t rd_addr,
   output logic link_timeout
);
   import pgm_pkg::*;

   localparam cnt_t TIMEOUT_C = cnt_t'(IDLE_TIMEOUT_CYC);
   localparam cnt_t BIT_MIN_C = cnt_t'(`PGM_US2CYC(`PGM_BIT_MIN_US));
   localparam cnt_t BIT_MAX_C = cnt_t'(BIT_MAX_CYC);
   localparam cnt_t START_LOW_C = cnt_t'(`PGM_US2CYC(`PGM_START_LOW_US));
   localparam cnt_t STOP_HIGH_C = cnt_t'(`PGM_US2CYC(`PGM_STOP_HIGH_US));
   localparam logic [4:0] CMD_LAST = 5'(`PGM_CMD_BITS - 1);
   localparam logic [4:0] FRAME_LAST = 5'(`PGM_CMD_BITS + `PGM_DATA_BITS - 1);
   localparam logic [4:0] TX_LAST = 5'(`PGM_DATA_BITS);

   if (IDLE_TIMEOUT_CYC <= BIT_MAX_CYC || IDLE_TIMEOUT_CYC > 65535
       || BIT_MAX_CYC < `PGM_US2CYC(`PGM_BIT_MIN_US) || POWER_UP_CYC < 1 || ENTRY_WINDOW_CYC < 1)
   begin : g_check
      $error("pgm_slave: timeout, bit period or mode timing out of range");
   end

   logic [2:0] sync;
   logic lvl;
   logic lvl_d;
   cnt_t since_rise;
   cnt_t high_cnt;
   cnt_t low_cnt;
   logic [31:0] up_time;
   slave_state_e state, next_state;
   logic [4:0] bitn, next_bitn;
   logic [23:0] shreg, next_shreg;
   cnt_t period, next_period;
   cnt_t tx_t, next_tx_t;
   logic [16:0] tx_sh, next_tx_sh;
   logic [4:0] txn, next_txn;
   logic drv_oe, next_drv_oe;
   logic drv_out, next_drv_out;
   logic pin_oe;
   logic pin_out;
   logic next_cmd_mode;
   logic next_wr_strobe;
   logic next_rd_strobe;
   logic next_timeout;

   // Edge and timing decode of the filtered pin level.
   wire rise = lvl & ~lvl_d;
   wire fall = ~lvl & lvl_d;
   wire cnt_t cell_len = sat_inc(since_rise); // The timer restarts a cycle after the rise it measures from.
   wire cell_ok = (cell_len >= BIT_MIN_C) && (cell_len <= BIT_MAX_C); // [R19]
   wire rx_bit = decode_bit(high_cnt, since_rise); // [R15] [R21]
   wire timed_out = since_rise >= TIMEOUT_C; // [R11] [R18]
   wire cnt_t tx_inc = cnt_t'(tx_t + 16'h1);
   wire powered = up_time >= 32'(POWER_UP_CYC);
   wire in_window = up_time < 32'(ENTRY_WINDOW_CYC);
   wire sig_ok = (shreg[15:0] == `PGM_SIG_A) || (shreg[15:0] == `PGM_SIG_B);
   wire entry_hit = in_window && (shreg[23:17] == SIG_ADDR) && sig_ok && !shreg[16];

   // Command and data fields come straight out of the receive shift register.
   assign wr_addr = shreg[23:17]; // [R20]
   assign wr_data = shreg[15:0];
   assign rd_addr = shreg[7:1];
   assign link.s_oe = pin_oe; // [R1]
   assign link.s_out = pin_out;

   // Three-stage pin filter plus the cell timers; the first stage feeds only the second.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync <= 3'h7;
         lvl <= 1'h1;
         lvl_d <= 1'h1;
         since_rise <= 16'hFFFF;
         high_cnt <= 16'h0;
         low_cnt <= 16'h0;
         up_time <= 32'h0;
      end
      else
      begin
         sync <= {sync[1:0], link.line};
         lvl <= (sync[1] == sync[2]) ? sync[2] : lvl;
         lvl_d <= lvl;
         since_rise <= rise ? 16'h0 : sat_inc(since_rise);
         high_cnt <= rise ? 16'h0 : (lvl ? sat_inc(high_cnt) : high_cnt);
         low_cnt <= lvl ? 16'h0 : sat_inc(low_cnt);
         up_time <= (&up_time) ? up_time : 32'(up_time + 32'h1);
      end
   end

   // Frame engine: the sensor only ever answers what the master opened.
   always_comb
   begin
      next_state = state;
      next_bitn = bitn;
      next_shreg = shreg;
      next_period = period;
      next_tx_t = tx_t;
      next_tx_sh = tx_sh;
      next_txn = txn;
      next_drv_oe = drv_oe;
      next_drv_out = drv_out;
      next_cmd_mode = cmd_mode;
      next_wr_strobe = 1'h0;
      next_rd_strobe = 1'h0;
      next_timeout = 1'h0;
      unique case (state)
         S_IDLE:
         begin
            next_drv_oe = 1'h0;
            if (rise && low_cnt >= START_LOW_C) // [R5] [R14]
            begin
               next_bitn = 5'h0;
               next_state = S_RX;
            end
         end
         S_RX:
         begin
            if (rise)
            begin
               if (!cell_ok)
                  next_state = S_IDLE;
               else
               begin
                  next_shreg = {shreg[22:0], rx_bit}; // [R7] [R20]
                  next_bitn = 5'(bitn + 5'h1);
                  if (bitn == CMD_LAST && rx_bit)
                  begin
                     // Reads are refused until command mode is open.
                     next_rd_strobe = cmd_mode; // [R16]
                     next_period = cell_len;
                     next_state = cmd_mode ? S_HO_RX : S_IDLE;
                  end
                  else if (bitn == FRAME_LAST)
                     next_state = S_STOP_HOLD; // [R8]
               end
            end
         end
         S_HO_RX:
         begin
            if (fall) // [R9] [R22]
            begin
               next_tx_sh = {rd_data, 1'h0};
               next_drv_oe = 1'h1;
               next_drv_out = 1'h0;
               next_state = S_TAKE;
            end
         end
         S_TAKE:
         begin
            // Keep the cell grid so the master has released before our first edge.
            if (since_rise >= period)
            begin
               next_tx_t = 16'h0;
               next_txn = 5'h0;
               next_drv_out = 1'h1;
               next_state = S_TX;
            end
         end
         S_TX:
         begin
            if (txn == TX_LAST && tx_inc >= high_width(1'h1, period)) // [R9] [R22]
            begin
               next_drv_oe = 1'h0;
               next_state = S_WAIT_STOP;
            end
            else if (tx_inc >= period)
            begin
               next_tx_t = 16'h0;
               next_tx_sh = {tx_sh[15:0], 1'h0};
               next_txn = 5'(txn + 5'h1);
               next_drv_out = 1'h1;
            end
            else
            begin
               next_tx_t = tx_inc;
               next_drv_out = tx_inc < high_width(tx_sh[16], period); // [R8] [R15]
            end
         end
         S_WAIT_STOP:
         begin
            if (rise)
               next_state = S_IDLE;
         end
         S_STOP_HOLD:
         begin
            // A write counts only after a full stop HIGH; a short stop discards it.
            if (fall)
               next_state = S_IDLE;
            else if (since_rise >= STOP_HIGH_C) // [R14]
            begin
               next_state = S_IDLE;
               next_wr_strobe = cmd_mode; // [R16]
               if (entry_hit)
                  next_cmd_mode = 1'h1; // [R12] [R13]
            end
         end
      endcase
      if (state != S_IDLE && timed_out) // [R11] [R18]
      begin
         next_state = S_IDLE;
         next_drv_oe = 1'h0;
         next_timeout = 1'h1;
      end
   end

   // Pin drive: analog/SENT level in normal mode, link drive once command mode is open.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_oe <= 1'h0;
         pin_out <= 1'h0;
         normal_mode <= 1'h0;
      end
      else
      begin
         pin_oe <= cmd_mode ? drv_oe : powered; // [R2] [R22]
         pin_out <= cmd_mode ? drv_out : normal_level; // [R1]
         normal_mode <= powered && !next_cmd_mode; // [R2] [R13]
      end
   end

   // Frame state registers; command mode only ever sets, reset alone clears it.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= S_IDLE;
         bitn <= 5'h0;
         shreg <= 24'h0;
         period <= 16'h0;
         tx_t <= 16'h0;
         tx_sh <= 17'h0;
         txn <= 5'h0;
         drv_oe <= 1'h0;
         drv_out <= 1'h0;
         cmd_mode <= 1'h0;
         wr_strobe <= 1'h0;
         rd_strobe <= 1'h0;
         link_timeout <= 1'h0;
      end
      else
      begin
         state <= next_state;
         bitn <= next_bitn;
         shreg <= next_shreg;
         period <= next_period;
         tx_t <= next_tx_t;
         tx_sh <= next_tx_sh;
         txn <= next_txn;
         drv_oe <= next_drv_oe;
         drv_out <= next_drv_out;
         cmd_mode <= next_cmd_mode; // [R13]
         wr_strobe <= next_wr_strobe;
         rd_strobe <= next_rd_strobe;
         link_timeout <= next_timeout;
      end
   end
endmodule : pgm_slave

// ---- design/owi_consts.svh ----
`ifndef PGM_CONSTS_SVH
`define PGM_CONSTS_SVH

// Clock rate in MHz and the link's timing figures, each in microseconds.
`define PGM_CLK_MHZ 100
`define PGM_IDLE_TIMEOUT_US 250
`define PGM_START_LOW_US 5
`define PGM_STOP_HIGH_US 5
`define PGM_BIT_MIN_US 10
`define PGM_BIT_MAX_US 100
`define PGM_US2CYC(us) ((us) * `PGM_CLK_MHZ)

// Frame layout: command byte then two data bytes, most significant bit first.
`define PGM_CMD_BITS 8
`define PGM_DATA_BITS 16
`define PGM_RW_BIT 0

// Signature words that open command mode.
`define PGM_SIG_A 16'h7253
`define PGM_SIG_B 16'h8364

`endif

// ---- design/owi_pkg.sv ----
package pgm_pkg;
   typedef logic [15:0] cnt_t;
   typedef logic [15:0] word_t;
   typedef logic [7:0] cmd_t;
   typedef logic [6:0] addr_t;
   typedef enum {S_IDLE, S_RX, S_HO_RX, S_TAKE, S_TX, S_WAIT_STOP, S_STOP_HOLD} slave_state_e;
   typedef enum {M_IDLE, M_PRE, M_START, M_CELL, M_HO, M_RX, M_TKO_WAIT, M_TKO, M_STOP} master_state_e;

   // HIGH time of a cell: three quarters of the period for a one, one quarter for a zero.
   function automatic cnt_t high_width(input logic bit_val, input cnt_t period);
      cnt_t quarter;
      quarter = period >> 2;
      return bit_val ? cnt_t'(period - quarter) : quarter;
   endfunction : high_width

   // A cell reads as one when its HIGH time exceeds half of its period.
   function automatic logic decode_bit(input cnt_t high, input cnt_t period);
      return {high, 1'h0} > {1'h0, period};
   endfunction : decode_bit

   // Counter step that stops at the top instead of wrapping.
   function automatic cnt_t sat_inc(input cnt_t c);
      return (&c) ? c : cnt_t'(c + 16'h1);
   endfunction : sat_inc
endpackage : pgm_pkg

// ---- design/owi_if.sv ----
`timescale 1ns/1ps
interface pgm_if;
   logic m_out;
   logic m_oe;
   logic s_out;
   logic s_oe;
   logic line;

   // The master overdrives the sensor buffer, so its drive wins; an undriven pin is pulled up.
   assign line = m_oe ? m_out : (s_oe ? s_out : 1'h1); // [R4]

   modport master (output m_out, output m_oe, input line);
   modport slave (output s_out, output s_oe, input line);
endinterface : pgm_if

// ---- design/owi_master.sv ----
`timescale 1ns/1ps
`include "owi_consts.svh"
module pgm_master #(
   parameter int BIT_CYC = 2000,
   parameter int IDLE_TIMEOUT_CYC = `PGM_US2CYC(`PGM_IDLE_TIMEOUT_US)
)
(
   pgm_if.master link,
   input wire logic clk,
   input wire logic rstn,
   input wire logic start_req,
   input wire pgm_pkg::cmd_t cmd,
   input wire pgm_pkg::word_t wdata,
   output logic busy,
   output logic done,
   output logic fail,
   output pgm_pkg::word_t rdata
);
   import pgm_pkg::*;

   localparam cnt_t PER = cnt_t'(BIT_CYC);
   localparam cnt_t TIMEOUT_C = cnt_t'(IDLE_TIMEOUT_CYC);
   localparam cnt_t START_LOW_C = cnt_t'(`PGM_US2CYC(`PGM_START_LOW_US));
   localparam cnt_t STOP_HIGH_C = cnt_t'(`PGM_US2CYC(`PGM_STOP_HIGH_US));
   localparam logic [4:0] CMD_LAST = 5'(`PGM_CMD_BITS - 1);
   localparam logic [4:0] FRAME_LAST = 5'(`PGM_CMD_BITS + `PGM_DATA_BITS - 1);
   localparam logic [4:0] RX_LAST = 5'(`PGM_DATA_BITS);

   if (BIT_CYC < `PGM_US2CYC(`PGM_BIT_MIN_US) || BIT_CYC > `PGM_US2CYC(`PGM_BIT_MAX_US)
       || IDLE_TIMEOUT_CYC <= BIT_CYC || IDLE_TIMEOUT_CYC > 65535)
   begin : g_check
      $error("pgm_master: bit period or timeout out of range");
   end

   logic [2:0] sync;
   logic lvl;
   logic lvl_d;
   cnt_t since_rise;
   cnt_t high_cnt;
   master_state_e state, next_state;
   cnt_t t, next_t;
   logic [4:0] n, next_n;
   logic [23:0] tx_sh, next_tx_sh;
   logic is_read, next_is_read;
   logic oe, next_oe;
   logic out, next_out;
   logic next_busy;
   logic next_done;
   logic next_fail;
   word_t next_rdata;

   wire rise = lvl & ~lvl_d;
   wire fall = ~lvl & lvl_d;
   wire rx_bit = decode_bit(high_cnt, since_rise);
   wire cnt_t t_inc = cnt_t'(t + 16'h1);
   wire listening = (state == M_RX) || (state == M_TKO_WAIT);

   assign link.m_oe = oe;
   assign link.m_out = out;

   // The pin is asynchronous to us; a level counts once the second and third stages agree.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync <= 3'h7;
         lvl <= 1'h1;
         lvl_d <= 1'h1;
         since_rise <= 16'h0;
         high_cnt <= 16'h0;
      end
      else
      begin
         sync <= {sync[1:0], link.line};
         lvl <= (sync[1] == sync[2]) ? sync[2] : lvl;
         lvl_d <= lvl;
         since_rise <= rise ? 16'h0 : sat_inc(since_rise);
         high_cnt <= rise ? 16'h0 : (lvl ? sat_inc(high_cnt) : high_cnt);
      end
   end

   // Transaction sequencer; the master always owns the pin outside reset and the read data phase.
   always_comb
   begin
      next_state = state;
      next_t = t;
      next_n = n;
      next_tx_sh = tx_sh;
      next_is_read = is_read;
      next_oe = oe;
      next_out = out;
      next_busy = busy;
      next_done = 1'h0;
      next_fail = fail;
      next_rdata = rdata;
      unique case (state)
         M_IDLE:
         begin
            next_oe = 1'h1; // [R4] [R5]
            next_out = 1'h1;
            if (start_req)
            begin
               next_tx_sh = {cmd, wdata}; // [R20]
               next_is_read = cmd[`PGM_RW_BIT];
               next_t = 16'h0;
               next_busy = 1'h1;
               next_fail = 1'h0;
               next_state = M_PRE;
            end
         end
         M_PRE:
         begin
            next_t = t_inc;
            if (t_inc >= TIMEOUT_C) // [R3] [R12]
            begin
               next_t = 16'h0;
               next_out = 1'h0;
               next_state = M_START;
            end
         end
         M_START:
         begin
            next_t = t_inc;
            if (t_inc >= START_LOW_C) // [R6] [R14] [R19]
            begin
               next_t = 16'h0;
               next_n = 5'h0;
               next_out = 1'h1;
               next_state = M_CELL;
            end
         end
         M_CELL:
         begin
            if (t_inc >= PER) // [R15]
            begin
               next_t = 16'h0;
               next_out = 1'h1;
               if (n == (is_read ? CMD_LAST : FRAME_LAST)) // [R7] [R8]
                  next_state = is_read ? M_HO : M_STOP;
               else
               begin
                  next_n = 5'(n + 5'h1);
                  next_tx_sh = {tx_sh[22:0], 1'h0};
               end
            end
            else
            begin
               next_t = t_inc;
               next_out = t_inc < high_width(tx_sh[23], PER);
            end
         end
         M_HO:
         begin
            // Handover zero; let go of the pin at three quarters of the cell.
            next_t = t_inc;
            next_out = t_inc < high_width(1'h0, PER);
            if (t_inc >= high_width(1'h1, PER)) // [R9]
            begin
               next_oe = 1'h0;
               next_n = 5'h0;
               next_state = M_RX;
            end
         end
         M_RX:
         begin
            if (rise)
            begin
               next_n = 5'(n + 5'h1);
               if (n != 5'h0)
                  next_rdata = {rdata[14:0], rx_bit}; // [R8] [R15]
               if (n == RX_LAST)
                  next_state = M_TKO_WAIT;
            end
         end
         M_TKO_WAIT:
         begin
            if (fall) // [R9]
            begin
               next_oe = 1'h1;
               next_out = 1'h0;
               next_t = 16'h0;
               next_state = M_TKO;
            end
         end
         M_TKO:
         begin
            next_t = t_inc;
            if (t_inc >= (PER >> 1)) // [R10]
            begin
               next_out = 1'h1;
               next_t = 16'h0;
               next_state = M_STOP;
            end
         end
         M_STOP:
         begin
            next_out = 1'h1;
            next_t = t_inc;
            if (t_inc >= STOP_HIGH_C) // [R10] [R14]
            begin
               next_done = 1'h1;
               next_busy = 1'h0;
               next_state = M_IDLE;
            end
         end
      endcase
      // A sensor that never answers must not hang the master.
      if (listening && since_rise >= TIMEOUT_C)
      begin
         next_oe = 1'h1;
         next_out = 1'h1;
         next_done = 1'h1;
         next_fail = 1'h1;
         next_busy = 1'h0;
         next_state = M_IDLE;
      end
   end

   // State and output registers.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= M_IDLE;
         t <= 16'h0;
         n <= 5'h0;
         tx_sh <= 24'h0;
         is_read <= 1'h0;
         oe <= 1'h0;
         out <= 1'h1;
         busy <= 1'h0;
         done <= 1'h0;
         fail <= 1'h0;
         rdata <= 16'h0;
      end
      else
      begin
         state <= next_state;
         t <= next_t;
         n <= next_n;
         tx_sh <= next_tx_sh;
         is_read <= next_is_read;
         oe <= next_oe;
         out <= next_out;
         busy <= next_busy;
         done <= next_done;
         fail <= next_fail;
         rdata <= next_rdata;
      end
   end
endmodule : pgm_master

// ---- testbench/owi_link_sva.sv ----
`timescale 1ns/1ps
module pgm_link_sva #(
   parameter int BIT_CYC = 1000,
   parameter int IDLE_TIMEOUT_CYC = 2000
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic m_out,
   input wire logic m_oe,
   input wire logic s_out,
   input wire logic s_oe,
   input wire logic line,
   input wire logic normal_mode,
   input wire logic cmd_mode,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic link_timeout
);
   import pgm_pkg::*;
   localparam int QTR = BIT_CYC / 4;
   cnt_t high_cnt;
   cnt_t gap_cnt;

   default clocking dflt @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // HIGH time of the pin and silence since its last rise; both saturate so long idles never wrap.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         high_cnt <= 16'h0000;
         gap_cnt <= 16'h0000;
      end
      else
      begin
         high_cnt <= !line ? 16'h0000 : ((&high_cnt) ? high_cnt : high_cnt + 16'h0001);
         gap_cnt <= $rose(line) ? 16'h0000 : ((&gap_cnt) ? gap_cnt : gap_cnt + 16'h0001);
      end
   end

   // The sensor takes the pin with a LOW and hands it back after a LOW.
   sequence s_takeover;
      cmd_mode && $rose(s_oe);
   endsequence
   sequence s_handback;
      $past(cmd_mode) && $fell(s_oe);
   endsequence

   a_mode_sticky: assert property (cmd_mode |=> cmd_mode)
      else $error("command mode dropped");
   a_modes_exclusive: assert property (!(normal_mode && cmd_mode))
      else $error("normal and command mode together");
   a_read_needs_cmd: assert property (rd_strobe |-> cmd_mode)
      else $error("read strobe outside command mode");
   a_write_needs_cmd: assert property (wr_strobe |-> $past(cmd_mode))
      else $error("write strobe outside command mode");
   a_power_up_drive: assert property ($rose(normal_mode) |-> ##[0:2] s_oe)
      else $error("normal output not driven");
   a_takeover_low: assert property (s_takeover |-> !s_out)
      else $error("takeover not LOW");
   a_handback_low: assert property (s_handback |-> !$past(s_out))
      else $error("handback not LOW");
   // Overlap of both drivers is only legal while both pull LOW; the settle delay skips mode entry.
   a_overlap_low: assert property (cmd_mode && $past(cmd_mode, 8) && m_oe && s_oe |-> !m_out && !s_out)
      else $error("drivers overlap on HIGH");
   a_cell_width: assert property ($fell(line) |->
      high_cnt inside {[QTR-2:QTR+2], [3*QTR-2:3*QTR+2]} || high_cnt >= IDLE_TIMEOUT_CYC)
      else $error("HIGH width fits no bit value");
   a_timeout_silence: assert property (link_timeout |-> gap_cnt >= IDLE_TIMEOUT_CYC - 2)
      else $error("timeout before silence ran out");
   a_timeout_release: assert property (link_timeout && cmd_mode |-> ##[0:2] !s_oe)
      else $error("drive kept after timeout");
endmodule : pgm_link_sva

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`include "owi_consts.svh"
module tb;
   import pgm_pkg::*;
   localparam int TO_CYC = 1500;
   localparam int BIT_CYC = 1000;
   logic clk;
   logic rstn;
   logic start_req;
   cmd_t cmd;
   word_t wdata;
   logic busy;
   logic done;
   logic fail;
   word_t rdata;
   logic normal_level;
   word_t rd_data;
   logic normal_mode;
   logic cmd_mode;
   logic wr_strobe;
   logic rd_strobe;
   logic link_timeout;
   addr_t wr_addr;
   addr_t rd_addr;
   word_t wr_data;
   int err_count;
   int cmp_count;
   int wr_seen;
   int rd_seen;
   int to_seen;
   addr_t seen_addr;
   word_t seen_data;

   pgm_if link_bus();
   pgm_master #(.BIT_CYC(BIT_CYC), .IDLE_TIMEOUT_CYC(TO_CYC)) u_pgm_master (.link(link_bus), .clk(clk),
      .rstn(rstn), .start_req(start_req), .cmd(cmd), .wdata(wdata), .busy(busy), .done(done), .fail(fail),
      .rdata(rdata));
   pgm_slave #(.IDLE_TIMEOUT_CYC(TO_CYC), .BIT_MAX_CYC(1200), .POWER_UP_CYC(20), .ENTRY_WINDOW_CYC(200000))
      u_pgm_slave (.link(link_bus), .clk(clk), .rstn(rstn), .normal_level(normal_level), .rd_data(rd_data),
      .normal_mode(normal_mode), .cmd_mode(cmd_mode), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_strobe(rd_strobe), .rd_addr(rd_addr), .link_timeout(link_timeout));
   pgm_link_sva #(.BIT_CYC(BIT_CYC), .IDLE_TIMEOUT_CYC(TO_CYC)) u_pgm_link_sva (.clk(clk), .rstn(rstn),
      .m_out(link_bus.m_out), .m_oe(link_bus.m_oe), .s_out(link_bus.s_out), .s_oe(link_bus.s_oe),
      .line(link_bus.line), .normal_mode(normal_mode), .cmd_mode(cmd_mode), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .link_timeout(link_timeout));

   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // Strobes last one cycle, so they are caught on the falling edge, away from the launching edge.
   always @(negedge clk)
   begin
      if (wr_strobe === 1'h1)
      begin
         wr_seen++;
         seen_addr = wr_addr;
         seen_data = wr_data;
      end
      if (rd_strobe === 1'h1)
      begin
         rd_seen++;
         seen_addr = rd_addr;
      end
      if (link_timeout === 1'h1)
         to_seen++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One whole frame from the master; the slave's write strobe trails the master's done by a few cycles.
   task automatic frame(input cmd_t c, input word_t w);
      int n;
      n = 0;
      @(posedge clk);
      start_req <= 1'h1;
      cmd <= c;
      wdata <= w;
      @(posedge clk);
      start_req <= 1'h0;
      while (done !== 1'h1 && n < 60000)
      begin
         @(negedge clk);
         n++;
      end
      check(16'(n < 60000), 16'h0001);
      repeat (20) @(negedge clk);
   endtask : frame

   task automatic tally_and_finish;
      $display("Mismatches %0d of %0d comparisons", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
      begin
         $display("Run complete: PASS");
      end
      else
      begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // Main sequence: refused read, signature entry, write, then read back.
   initial
   begin
      err_count = 0;
      cmp_count = 0;
      wr_seen = 0;
      rd_seen = 0;
      to_seen = 0;
      rstn = 1'h0;
      start_req = 1'h0;
      cmd = 8'h00;
      wdata = 16'h0000;
      normal_level = 1'h0;
      rd_data = 16'hC35A;
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      repeat (30) @(negedge clk);
      check(16'(normal_mode), 16'h0001);
      check(16'(link_bus.s_oe), 16'h0001);
      check(16'(link_bus.s_out), 16'h0000);
      frame(8'h2B, 16'h0000);
      check(16'(fail), 16'h0001);
      check(16'(rd_seen), 16'h0000);
      frame(8'h00, `PGM_SIG_A);
      // The refused read leaves the line LOW; its release looks like a start that must time out.
      check(16'(to_seen), 16'h0001);
      check(16'(cmd_mode), 16'h0001);
      check(16'(normal_mode), 16'h0000);
      check(16'(link_bus.s_oe), 16'h0000);
      wr_seen = 0;
      frame(8'h2A, 16'hA5C3);
      check(16'(wr_seen), 16'h0001);
      check(16'(seen_addr), 16'h0015);
      check(seen_data, 16'hA5C3);
      frame(8'h2B, 16'h0000);
      check(16'(fail), 16'h0000);
      check(rdata, 16'hC35A);
      check(16'(rd_seen), 16'h0001);
      check(16'(seen_addr), 16'h0015);
      check(16'(cmd_mode), 16'h0001);
      // Only a power-on reset leaves command mode.
      @(posedge clk);
      rstn <= 1'h0;
      repeat (5) @(posedge clk);
      rstn <= 1'h1;
      repeat (30) @(negedge clk);
      check(16'(cmd_mode), 16'h0000);
      check(16'(normal_mode), 16'h0001);
      tally_and_finish();
   end

   // Four frames and a reset need about 93000 cycles; a hang is caught soon after that.
   initial
   begin
      repeat (100000) @(posedge clk);
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, 16'h0000, 16'h0001);
      tally_and_finish();
   end
endmodule : tb
